/* logic/ucss_regs.svh */
// Constants for the USB conditioner strap and status block
`ifndef UCSS_REGS_SVH
`define UCSS_REGS_SVH

// Clock period of ref_clk_i
`define UCSS_CLK_PERIOD_NS 10
// Chirp duration window, in ns
`define UCSS_CHIRP_MIN_NS 18000
`define UCSS_CHIRP_MAX_NS 128000
// Chirp counter width, holds max count plus one
`define UCSS_CNT_W 14
// Fixed I2C target address
`define UCSS_I2C_ADDR 7'h2c
// Highest AC boost level, chosen for a floating select
`define UCSS_AC_MAX 2'h3
// Number of pin inputs that pass the synchroniser
`define UCSS_SYNC_W 17
// Width of the AC range comparator code
`define UCSS_AC_RANGE_W 3
// Reset value of synchronised pins
`define UCSS_SYNC_RST 17'h00000

`endif

/* logic/ucss_pkg.sv */
// Types for the USB conditioner strap and status block
`default_nettype none
package ucss_pkg;

  // Dc_gain_strap selection captured from the three-level strap
  typedef enum logic [1:0] {
    UCSS_DC_40MV,
    UCSS_DC_60MV,
    UCSS_DC_80MV
  } ucss_dc_t;

  // Line supervision states
  typedef enum logic [2:0] {
    UCSS_LINK_OFF,
    UCSS_LINK_UNCONN,
    UCSS_LINK_FIXTURE,
    UCSS_LINK_ATTACHED,
    UCSS_LINK_HS
  } ucss_link_t;

  // Chirp pair checker states
  typedef enum logic [1:0] {
    UCSS_CHIRP_IDLE,
    UCSS_CHIRP_J,
    UCSS_CHIRP_K
  } ucss_chirp_t;

endpackage
`default_nettype wire

/* logic/ucss_sync.sv */
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
`include "ucss_regs.svh"
module ucss_sync #(
  parameter int unsigned W = `UCSS_SYNC_W
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Pins and filtered result
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  // Stage one is read only by stage two
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s1_q <= W'(`UCSS_SYNC_RST);
      s2_q <= W'(`UCSS_SYNC_RST);
      s3_q <= W'(`UCSS_SYNC_RST);
    end else begin
      s1_q <= d_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A bit changes only once stages two and three agree
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
          out_q[g] <= 1'b0;
        end else if (s2_q[g] == s3_q[g]) begin
          out_q[g] <= s3_q[g];
        end
      end
    end
  endgenerate

  assign q_o = out_q;

endmodule
`default_nettype wire

/* logic/ucss_chirp.sv */
// Chirp J then chirp K pair duration checker
`timescale 1ns/1ns
`default_nettype none
`include "ucss_regs.svh"
module ucss_chirp #(
  parameter int unsigned MIN_CYC = 1,
  parameter int unsigned MAX_CYC = 2
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic clear_i,
  // Line chirp detectors, already synchronised
  input wire logic chirp_j_i,
  input wire logic chirp_k_i,
  // One-cycle pulse on a good pair
  output logic pair_ok_o
);

  localparam logic [`UCSS_CNT_W-1:0] MIN_C = `UCSS_CNT_W'(MIN_CYC);
  localparam logic [`UCSS_CNT_W-1:0] MAX_C = `UCSS_CNT_W'(MAX_CYC);
  localparam logic [`UCSS_CNT_W-1:0] ONE_C = `UCSS_CNT_W'(1);

  ucss_pkg::ucss_chirp_t state_q;
  logic [`UCSS_CNT_W-1:0] cnt_q;
  logic ok_q;
  logic in_range;

  // Saturating at max plus one keeps an overlong chirp out of range
  assign in_range = (cnt_q >= MIN_C) && (cnt_q <= MAX_C);

  // Chirp length measurement
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || clear_i) begin
      state_q <= ucss_pkg::UCSS_CHIRP_IDLE;
      cnt_q <= ONE_C;
      ok_q <= 1'b0;
    end else begin
      ok_q <= 1'b0;
      unique case (state_q)
        ucss_pkg::UCSS_CHIRP_IDLE: begin
          cnt_q <= ONE_C;
          if (chirp_j_i) begin
            state_q <= ucss_pkg::UCSS_CHIRP_J;
          end
        end
        ucss_pkg::UCSS_CHIRP_J: begin
          if (chirp_j_i) begin
            if (cnt_q <= MAX_C) cnt_q <= cnt_q + ONE_C;
          end else if (chirp_k_i && in_range) begin
            state_q <= ucss_pkg::UCSS_CHIRP_K;
            cnt_q <= ONE_C;
          end else begin
            state_q <= ucss_pkg::UCSS_CHIRP_IDLE;
          end
        end
        ucss_pkg::UCSS_CHIRP_K: begin
          if (chirp_k_i) begin
            if (cnt_q <= MAX_C) cnt_q <= cnt_q + ONE_C;
          end else begin
            ok_q <= in_range;
            state_q <= ucss_pkg::UCSS_CHIRP_IDLE;
          end
        end
        default: begin
          state_q <= ucss_pkg::UCSS_CHIRP_IDLE;
        end
      endcase
    end
  end

  assign pair_ok_o = ok_q;

  a_chirp_ok_len: assert property (@(posedge ref_clk_i) disable iff (reset_i)
    $rose(ok_q) |-> $past(in_range) && $past(state_q == ucss_pkg::UCSS_CHIRP_K))
    else $error("chirp pair accepted with bad length");

endmodule
`default_nettype wire

/* logic/ucss_top.sv */
// Strap capture and line status logic of the USB signal conditioner
`timescale 1ns/1ns
`default_nettype none
`include "ucss_regs.svh"
module ucss_top #(
  parameter int unsigned CHIRP_MAX_CYC = `UCSS_CHIRP_MAX_NS / `UCSS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // Device reset pin, low holds reset
  input wire logic chip_reset_low_i,
  // Strap levels of the shared I2C pins
  input wire logic sda_strap_i,
  input wire logic scl_strap_i,
  // AC gain select: floating detect and pull-down range thermometer
  input wire logic ac_gain_float_i,
  input wire logic [`UCSS_AC_RANGE_W-1:0] ac_gain_select_i,
  // DC gain strap three-level comparators
  input wire logic dc_gain_strap_hi_i,
  input wire logic dc_gain_strap_lo_i,
  // Line detectors
  input wire logic pullup_detect_i,
  input wire logic disconnect_i,
  input wire logic fixture_detect_i,
  input wire logic test_packet_i,
  input wire logic bus_reset_i,
  input wire logic squelch_i,
  input wire logic chirp_j_i,
  input wire logic chirp_k_i,
  // Mode and configuration
  output logic shutdown_o,
  output logic i2c_mode_o,
  output logic [6:0] i2c_target_addr_o,
  output logic [1:0] ac_level_o,
  output ucss_pkg::ucss_dc_t dc_level_o,
  // Shared clock pin as attach flag output
  output logic attach_detected_flag_o,
  output logic attach_flag_oe_o,
  // Shared DC pin as high-speed flag output
  output logic high_speed_active_flag_o,
  output logic hs_flag_oe_o,
  // Core regulator enable
  output logic core_regulator_out_o
);

  localparam int unsigned CHIRP_MIN_CYC =
    (`UCSS_CHIRP_MIN_NS + `UCSS_CLK_PERIOD_NS - 1) / `UCSS_CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [`UCSS_SYNC_W-1:0] sync_q;
  logic run, s_sda, s_scl, s_ac_float, s_dc_hi, s_dc_lo;
  logic [`UCSS_AC_RANGE_W-1:0] s_ac_range;
  logic s_pullup, s_disc, s_fixture, s_packet, s_bus_reset, s_squelch, s_chirp_j, s_chirp_k;

  ucss_sync #(
    .W(`UCSS_SYNC_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .d_i({chip_reset_low_i, sda_strap_i, scl_strap_i, ac_gain_float_i,
          ac_gain_select_i, dc_gain_strap_hi_i, dc_gain_strap_lo_i,
          pullup_detect_i, disconnect_i, fixture_detect_i, test_packet_i,
          bus_reset_i, squelch_i, chirp_j_i, chirp_k_i}),
    .q_o(sync_q)
  );

  // Unpack the filtered pins in the same order
  assign {run, s_sda, s_scl, s_ac_float, s_ac_range, s_dc_hi, s_dc_lo,
          s_pullup, s_disc, s_fixture, s_packet, s_bus_reset, s_squelch,
          s_chirp_j, s_chirp_k} = sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // Strap decoding

  // Thermometer code from the pull-down range comparators to a level
  function automatic logic [1:0] ac_decode(input logic flt,
                                           input logic [`UCSS_AC_RANGE_W-1:0] rng);
    logic [1:0] lvl;
    lvl = 2'h0;
    if (flt) begin
      lvl = `UCSS_AC_MAX;
    end else begin
      for (int i = 0; i < `UCSS_AC_RANGE_W; i++) begin
        if (rng[i]) lvl = 2'(i + 1);
      end
    end
    return lvl;
  endfunction

  // Three-level strap; a conflict of both comparators reads as floating
  function automatic ucss_pkg::ucss_dc_t dc_decode(input logic hi, input logic lo);
    ucss_pkg::ucss_dc_t sel;
    sel = ucss_pkg::UCSS_DC_60MV;
    if (hi && !lo) sel = ucss_pkg::UCSS_DC_80MV;
    if (lo && !hi) sel = ucss_pkg::UCSS_DC_40MV;
    return sel;
  endfunction

  logic run_q;
  logic release_now;
  logic strap_i2c;
  logic [1:0] strap_ac;
  ucss_pkg::ucss_dc_t strap_dc;

  assign release_now = run && !run_q;
  assign strap_i2c = s_sda && s_scl;
  assign strap_ac = ac_decode(s_ac_float, s_ac_range);
  assign strap_dc = dc_decode(s_dc_hi, s_dc_lo);

  // Release edge tracker
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      run_q <= 1'b0;
    end else begin
      run_q <= run;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strap latches

  logic i2c_mode_q;
  logic [6:0] addr_q;
  logic [1:0] ac_q;
  ucss_pkg::ucss_dc_t dc_q;

  // Captured only on the release edge, so later pin changes are ignored
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      i2c_mode_q <= 1'b0;
      addr_q <= `UCSS_I2C_ADDR;
      ac_q <= `UCSS_AC_MAX;
      dc_q <= ucss_pkg::UCSS_DC_60MV;
    end else if (release_now) begin
      i2c_mode_q <= strap_i2c;
      addr_q <= `UCSS_I2C_ADDR;
      ac_q <= strap_ac;
      dc_q <= strap_dc;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Handshake tracking

  logic chirp_ok, bus_reset_q, hs_ok_q, reset_seen_q;

  ucss_chirp #(
    .MIN_CYC(CHIRP_MIN_CYC),
    .MAX_CYC(CHIRP_MAX_CYC)
  ) u_chirp (
    .ref_clk_i(ref_clk_i),
    .reset_i(reset_i),
    .clear_i(!run),
    .chirp_j_i(s_chirp_j),
    .chirp_k_i(s_chirp_k),
    .pair_ok_o(chirp_ok)
  );

  // A fresh bus reset discards any earlier handshake result
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !run || s_disc) begin
      bus_reset_q <= 1'b0;
      hs_ok_q <= 1'b0;
      reset_seen_q <= 1'b0;
    end else begin
      bus_reset_q <= s_bus_reset;
      if (s_bus_reset) reset_seen_q <= 1'b1;
      if (chirp_ok) begin
        hs_ok_q <= 1'b1;
      end else if (s_bus_reset && !bus_reset_q) begin
        hs_ok_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line state machine

  ucss_pkg::ucss_link_t link_q;
  logic hs_enter;

  // Squelch counts only once the bus reset has ended
  assign hs_enter = hs_ok_q && reset_seen_q && !s_bus_reset && s_squelch;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !run) begin
      link_q <= ucss_pkg::UCSS_LINK_OFF;
    end else begin
      unique case (link_q)
        ucss_pkg::UCSS_LINK_OFF: begin
          link_q <= ucss_pkg::UCSS_LINK_UNCONN;
        end
        ucss_pkg::UCSS_LINK_UNCONN: begin
          if (s_fixture) begin
            link_q <= ucss_pkg::UCSS_LINK_FIXTURE;
          end else if (s_pullup) begin
            link_q <= ucss_pkg::UCSS_LINK_ATTACHED;
          end
        end
        ucss_pkg::UCSS_LINK_FIXTURE: begin
          if (s_disc) begin
            link_q <= ucss_pkg::UCSS_LINK_UNCONN;
          end else if (s_packet) begin
            link_q <= ucss_pkg::UCSS_LINK_HS;
          end
        end
        ucss_pkg::UCSS_LINK_ATTACHED: begin
          if (s_disc) begin
            link_q <= ucss_pkg::UCSS_LINK_UNCONN;
          end else if (hs_enter) begin
            link_q <= ucss_pkg::UCSS_LINK_HS;
          end
        end
        ucss_pkg::UCSS_LINK_HS: begin
          if (s_disc) begin
            link_q <= ucss_pkg::UCSS_LINK_UNCONN;
          end else if (s_bus_reset) begin
            link_q <= ucss_pkg::UCSS_LINK_ATTACHED;
          end
        end
        default: begin
          link_q <= ucss_pkg::UCSS_LINK_OFF;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags and pin drive

  logic attach_q, attach_oe_q, hs_q, hs_oe_q;
  logic core_regulator_out_q, shutdown_q, hs_next;

  assign hs_next = (link_q == ucss_pkg::UCSS_LINK_HS);

  // Attach flag; disconnect wins over a late pull-up
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !run) begin
      attach_q <= 1'b0;
    end else if (s_disc) begin
      attach_q <= 1'b0;
    end else if (link_q == ucss_pkg::UCSS_LINK_UNCONN && s_pullup) begin
      attach_q <= 1'b1;
    end
  end

  // High-speed flag and regulator follow the state, one cycle late
  always_ff @(posedge ref_clk_i) begin
    if (reset_i || !run) begin
      hs_q <= 1'b0;
      core_regulator_out_q <= 1'b0;
    end else begin
      hs_q <= hs_next;
      core_regulator_out_q <= hs_next;
    end
  end

  // Pins drive only in strap mode and only after the straps are taken
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      attach_oe_q <= 1'b0;
      hs_oe_q <= 1'b0;
      shutdown_q <= 1'b1;
    end else begin
      attach_oe_q <= run_q && run && !i2c_mode_q;
      hs_oe_q <= run_q && run && !i2c_mode_q;
      shutdown_q <= !run;
    end
  end

  assign shutdown_o = shutdown_q;
  assign i2c_mode_o = i2c_mode_q;
  assign i2c_target_addr_o = addr_q;
  assign ac_level_o = ac_q;
  assign dc_level_o = dc_q;
  assign attach_detected_flag_o = attach_q;
  assign attach_flag_oe_o = attach_oe_q;
  assign high_speed_active_flag_o = hs_q;
  assign hs_flag_oe_o = hs_oe_q;
  assign core_regulator_out_o = core_regulator_out_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  a_shutdown_held: assert property (!run |=> shutdown_o && !high_speed_active_flag_o)
    else $error("not in shutdown while reset pin low");
  a_mode_capture: assert property (release_now |=> i2c_mode_o == $past(strap_i2c))
    else $error("mode strap not captured at release");
  a_ac_float_max: assert property (release_now && s_ac_float |=> ac_level_o == `UCSS_AC_MAX)
    else $error("floating AC select not at maximum");
  a_ac_ignore_late: assert property (run_q && run |=> $stable(ac_level_o) && $stable(dc_level_o))
    else $error("strap value changed after release");
  a_dc_high_80: assert property (release_now && s_dc_hi && !s_dc_lo
    |=> dc_level_o == ucss_pkg::UCSS_DC_80MV)
    else $error("DC strap high not decoded as 80 mV");
  a_attach_rise: assert property (run && link_q == ucss_pkg::UCSS_LINK_UNCONN && s_pullup && !s_disc
    |=> attach_detected_flag_o)
    else $error("attach flag missed pull-up");
  a_attach_drop: assert property (run && s_disc |=> !attach_detected_flag_o ##1 !high_speed_active_flag_o)
    else $error("flags not dropped on disconnect");
  a_pins_strap_only: assert property (attach_flag_oe_o || hs_flag_oe_o |-> !i2c_mode_o)
    else $error("status pin driven in I2C mode");
  a_hs_cause: assert property ($rose(high_speed_active_flag_o)
    |-> $past(hs_enter, 2) || $past(s_packet, 2))
    else $error("high-speed flag without a cause");
  a_core_regulator_out_hs: assert property (core_regulator_out_o == high_speed_active_flag_o)
    else $error("regulator and high-speed flag disagree");

endmodule
`default_nettype wire

/* verif/ucss_usb_model.sv */
// Behavioural model of the USB line pair as seen through the line detectors
`timescale 1ns/1ns
`default_nettype none
module ucss_usb_model (
  // Clock
  input wire logic ref_clk_i,
  // Detector levels towards the block
  output var logic pullup_detect_o,
  output var logic disconnect_o,
  output var logic fixture_detect_o,
  output var logic test_packet_o,
  output var logic bus_reset_o,
  output var logic squelch_o,
  output var logic chirp_j_o,
  output var logic chirp_k_o
);
  // Quiet, unconnected line at time zero
  initial begin
    {pullup_detect_o, disconnect_o, fixture_detect_o, test_packet_o} = 4'h0;
    {bus_reset_o, squelch_o, chirp_j_o, chirp_k_o} = 4'h0;
  end

  // Line conditions other than chirps, changed just after an edge
  task automatic drive(input logic [5:0] v);
    @(posedge ref_clk_i);
    {pullup_detect_o, disconnect_o, fixture_detect_o} <= v[5:3];
    {test_packet_o, bus_reset_o, squelch_o} <= v[2:0];
  endtask

  // One J then K pair; K follows J with no gap, lengths as commanded
  task automatic chirp_pair(input int j_len, input int k_len);
    @(posedge ref_clk_i);
    chirp_j_o <= 1'b1;
    repeat (j_len) @(posedge ref_clk_i);
    chirp_j_o <= 1'b0;
    chirp_k_o <= 1'b1;
    repeat (k_len) @(posedge ref_clk_i);
    chirp_k_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* verif/ucss_top_tb.sv */
// Self-checking bench for the strap capture and line status block
`timescale 1ns/1ns
`default_nettype none
module ucss_top_tb;
  // Full chirp window, 18 us to 128 us at 10 ns, so the end points are real
  localparam int unsigned MAX_CYC = 12800;
  localparam logic [5:0] L_PU = 6'h20;
  localparam logic [5:0] L_DIS = 6'h10;
  localparam logic [5:0] L_FIX = 6'h08;
  localparam logic [5:0] L_TP = 6'h04;
  localparam logic [5:0] L_BR = 6'h02;
  localparam logic [5:0] L_SQ = 6'h01;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic chip_reset_low_i = 1'b0;
  logic sda_strap_i = 1'b0;
  logic scl_strap_i = 1'b0;
  logic ac_gain_float_i = 1'b0;
  logic [2:0] ac_gain_select_i = 3'h0;
  logic dc_gain_strap_hi_i = 1'b0;
  logic dc_gain_strap_lo_i = 1'b0;
  wire logic pu, dis, fix, tp, br, sq, cj, ck;
  logic shutdown_o, i2c_mode_o, attach_detected_flag_o, attach_flag_oe_o;
  logic high_speed_active_flag_o, hs_flag_oe_o, core_regulator_out_o;
  logic [6:0] i2c_target_addr_o;
  logic [1:0] ac_level_o;
  ucss_pkg::ucss_dc_t dc_level_o;
  int fails = 0;
  int n_checks = 0;

  // Free-running 100 MHz clock
  always #5 ref_clk_i = ~ref_clk_i;

  ucss_top #(.CHIRP_MAX_CYC(MAX_CYC)) u_dut (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .chip_reset_low_i(chip_reset_low_i),
    .sda_strap_i(sda_strap_i), .scl_strap_i(scl_strap_i), .ac_gain_float_i(ac_gain_float_i),
    .ac_gain_select_i(ac_gain_select_i), .dc_gain_strap_hi_i(dc_gain_strap_hi_i),
    .dc_gain_strap_lo_i(dc_gain_strap_lo_i), .pullup_detect_i(pu), .disconnect_i(dis),
    .fixture_detect_i(fix), .test_packet_i(tp), .bus_reset_i(br), .squelch_i(sq),
    .chirp_j_i(cj), .chirp_k_i(ck), .shutdown_o(shutdown_o), .i2c_mode_o(i2c_mode_o),
    .i2c_target_addr_o(i2c_target_addr_o), .ac_level_o(ac_level_o), .dc_level_o(dc_level_o),
    .attach_detected_flag_o(attach_detected_flag_o), .attach_flag_oe_o(attach_flag_oe_o),
    .high_speed_active_flag_o(high_speed_active_flag_o), .hs_flag_oe_o(hs_flag_oe_o),
    .core_regulator_out_o(core_regulator_out_o)
  );

  ucss_usb_model u_usb (
    .ref_clk_i(ref_clk_i), .pullup_detect_o(pu), .disconnect_o(dis), .fixture_detect_o(fix),
    .test_packet_o(tp), .bus_reset_o(br), .squelch_o(sq), .chirp_j_o(cj), .chirp_k_o(ck)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, wait and report helpers
  task automatic chk_bit(input logic got, input logic exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_vec(input logic [6:0] got, input logic [6:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("checks=%0d fails=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // Bounded wait for a flag; sel 0 is attach, 1 is high speed
  task automatic wait_out(input int sel, input logic val, input int bound);
    int i;
    for (i = 0; i < bound; i++) begin
      @(posedge ref_clk_i);
      #1;
      if ((sel == 0 ? attach_detected_flag_o : high_speed_active_flag_o) === val) break;
    end
    chk_bit(core_regulator_out_o, high_speed_active_flag_o);
    if (i == bound) begin
      fails++;
      $display("FAIL t=%0t wait sel=%h got=%h exp=%h", $time, sel,
               (sel == 0 ? attach_detected_flag_o : high_speed_active_flag_o), val);
      final_report();
    end
  endtask

  // Pin reset with straps {sda, scl, float, code, hi, lo}, then release
  task automatic release_chip(input logic [7:0] st);
    @(posedge ref_clk_i);
    chip_reset_low_i <= 1'b0;
    {sda_strap_i, scl_strap_i, ac_gain_float_i, ac_gain_select_i} <= st[7:2];
    {dc_gain_strap_hi_i, dc_gain_strap_lo_i} <= st[1:0];
    repeat (8) @(posedge ref_clk_i);
    #1;
    chk_bit(shutdown_o, 1'b1);
    chk_bit(attach_detected_flag_o | high_speed_active_flag_o, 1'b0);
    chk_bit(core_regulator_out_o, 1'b0);
    @(posedge ref_clk_i);
    chip_reset_low_i <= 1'b1;
    repeat (12) @(posedge ref_clk_i);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  // Strap decode per case, then flipped straps must leave the capture alone
  task automatic t_straps();
    logic [7:0] st [5] = '{8'b11_1_000_10, 8'b10_0_000_01, 8'b01_0_001_00, 8'b00_0_011_11, 8'b10_0_111_01};
    logic [1:0] ac_x [5] = '{2'h3, 2'h0, 2'h1, 2'h2, 2'h3};
    logic [1:0] dc_x [5] = '{2'h2, 2'h0, 2'h1, 2'h1, 2'h0};
    logic i2c;
    for (int n = 0; n < 5; n++) begin
      release_chip(st[n]);
      i2c = st[n][7] & st[n][6];
      for (int p = 0; p < 2; p++) begin
        chk_bit(shutdown_o, 1'b0);
        chk_bit(i2c_mode_o, i2c);
        chk_vec(i2c_target_addr_o, 7'h2c);
        chk_vec({5'h00, ac_level_o}, {5'h00, ac_x[n]});
        if (!i2c) chk_vec({5'h00, dc_level_o}, {5'h00, dc_x[n]});
        chk_bit(attach_flag_oe_o, ~i2c);
        chk_bit(hs_flag_oe_o, ~i2c);
        @(posedge ref_clk_i);
        {sda_strap_i, scl_strap_i, ac_gain_float_i, ac_gain_select_i} <= ~st[n][7:2];
        {dc_gain_strap_hi_i, dc_gain_strap_lo_i} <= ~st[n][1:0];
        repeat (12) @(posedge ref_clk_i);
        #1;
      end
    end
  endtask

  // Attach flag is a level from pull-up to disconnect
  task automatic t_attach();
    release_chip(8'h20);
    chk_bit(attach_detected_flag_o, 1'b0);
    u_usb.drive(L_PU);
    wait_out(0, 1'b1, 20);
    u_usb.drive(6'h00);
    repeat (10) @(posedge ref_clk_i);
    #1;
    chk_bit(attach_detected_flag_o, 1'b1);
    u_usb.drive(L_DIS);
    wait_out(0, 1'b0, 20);
    u_usb.drive(6'h00);
  endtask

  // Fixture alone is not enough; test packet completes it; leaving drops it
  task automatic t_fixture();
    release_chip(8'h20);
    u_usb.drive(L_FIX);
    repeat (12) @(posedge ref_clk_i);
    #1;
    chk_bit(high_speed_active_flag_o, 1'b0);
    u_usb.drive(L_FIX | L_TP);
    wait_out(1, 1'b1, 20);
    u_usb.drive(L_DIS);
    wait_out(1, 1'b0, 20);
    u_usb.drive(L_FIX | L_TP);
    wait_out(1, 1'b1, 20);
    release_chip(8'h20);
    u_usb.drive(6'h00);
  endtask

  // Bus reset, one chirp pair, then squelch; only an in-range pair counts
  task automatic t_handshake(input int j_len, input int k_len, input logic good);
    release_chip(8'h20);
    u_usb.drive(L_PU);
    wait_out(0, 1'b1, 20);
    u_usb.drive(L_BR);
    u_usb.chirp_pair(j_len, k_len);
    repeat (8) @(posedge ref_clk_i);
    u_usb.drive(6'h00);
    u_usb.drive(L_SQ);
    if (good) begin
      wait_out(1, 1'b1, 20);
      u_usb.drive(L_BR);
      wait_out(1, 1'b0, 20);
    end else begin
      repeat (30) @(posedge ref_clk_i);
      #1;
      chk_bit(high_speed_active_flag_o, 1'b0);
    end
    u_usb.drive(6'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    @(posedge ref_clk_i);
    #1;
    chk_bit(shutdown_o, 1'b1);
    chk_vec(i2c_target_addr_o, 7'h2c);
    chk_vec({5'h00, ac_level_o}, 7'h03);
    @(posedge ref_clk_i);
    reset_i <= 1'b0;
    t_straps();
    t_attach();
    t_fixture();
    t_handshake(1800, 12800, 1'b1);
    t_handshake(1799, 1800, 1'b0);
    t_handshake(1800, 12801, 1'b0);
    final_report();
  end
endmodule
`default_nettype wire
